// File: logic/frtc_top.v
// Routing, input mode, page and trigger-operation control for the effects block.
// Assumes all panel, trigger and audio inputs are synchronous to clk_sys and
// that sample_valid pulses once per audio sample; the engines do the DSP.
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "frtc_defs.vh"
module frtc_top (
  input wire clk_sys,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire config_btn,
  input wire enc_step_up,
  input wire enc_step_down,
  input wire panel_trigger_btn,
  input wire external_trigger_in,
  input wire sample_valid,
  input wire [`FRTC_SMP_W-1:0] left_audio_in,
  input wire [`FRTC_SMP_W-1:0] right_audio_in,
  input wire right_jack_present,
  input wire [`FRTC_SMP_W-1:0] delay_out_l,
  input wire [`FRTC_SMP_W-1:0] delay_out_r,
  input wire [`FRTC_SMP_W-1:0] comb_out_l,
  input wire [`FRTC_SMP_W-1:0] comb_out_r,
  input wire [`FRTC_PTR_W-1:0] fb_tap_delay,
  output reg [`FRTC_SMP_W-1:0] delay_in_l_r,
  output reg [`FRTC_SMP_W-1:0] delay_in_r_r,
  output reg [`FRTC_SMP_W-1:0] comb_in_l_r,
  output reg [`FRTC_SMP_W-1:0] comb_in_r_r,
  output reg [`FRTC_SMP_W-1:0] audio_out_l_r,
  output reg [`FRTC_SMP_W-1:0] audio_out_r_r,
  output reg right_adc_en_r,
  output reg delay_wr_en_r,
  output reg [`FRTC_PTR_W-1:0] delay_wr_ptr_r,
  output reg [`FRTC_PTR_W-1:0] delay_rd_ptr_r,
  output reg freeze_on_r,
  output reg reverse_on_r,
  output reg random_event_r,
  output reg [`FRTC_DEST_W-1:0] random_dest_r,
  output reg [3:0] page_r,
  output reg [1:0] route_sel_r,
  output reg [1:0] input_mode_r,
  output reg [1:0] external_trigger_in_op_r
);
  wire cfg_press;
  wire enc_up;
  wire enc_dn;
  wire panel_rise;
  wire ext_rise;
  wire [`FRTC_SMP_W-1:0] rt_delay_l;
  wire [`FRTC_SMP_W-1:0] rt_delay_r;
  wire [`FRTC_SMP_W-1:0] rt_comb_l;
  wire [`FRTC_SMP_W-1:0] rt_comb_r;
  wire [`FRTC_SMP_W-1:0] rt_out_l;
  wire [`FRTC_SMP_W-1:0] rt_out_r;
  wire external_trigger_in_evt;
  wire bus_req;
  wire bus_wr;
  wire frz_tgl;
  wire [`FRTC_PTR_W-1:0] fb_eff;
  wire [`FRTC_PTR_W-1:0] rd_inc;
  reg [3:0] page_nxt;
  reg [1:0] route_nxt;
  reg [1:0] input_mode_nxt;
  reg [1:0] external_trigger_in_op_nxt;
  reg [`FRTC_DEST_W-1:0] dest_nxt;
  reg [31:0] rdata_nxt;
  reg [`FRTC_PTR_W-1:0] wr_ptr_r;
  reg [`FRTC_PTR_W-1:0] loop_end_r;

  // One-hot page states
  localparam [3:0] PG_IDLE = `FRTC_PG_IDLE;
  localparam [3:0] PG_ROUTE = `FRTC_PG_ROUTE;
  localparam [3:0] PG_INPUT = `FRTC_PG_INPUT;
  localparam [3:0] PG_EXTERNAL_TRIGGER_IN = `FRTC_PG_EXTERNAL_TRIGGER_IN;

  // Every button and trigger goes through the same one-pulse detector
  frtc_edge u_edge_cfg (
    .clk_sys(clk_sys),
    .rst(rst),
    .level_in(config_btn),
    .rise_pulse_r(cfg_press)
  );
  frtc_edge u_edge_up (
    .clk_sys(clk_sys),
    .rst(rst),
    .level_in(enc_step_up),
    .rise_pulse_r(enc_up)
  );
  frtc_edge u_edge_dn (
    .clk_sys(clk_sys),
    .rst(rst),
    .level_in(enc_step_down),
    .rise_pulse_r(enc_dn)
  );
  frtc_edge u_edge_panel (
    .clk_sys(clk_sys),
    .rst(rst),
    .level_in(panel_trigger_btn),
    .rise_pulse_r(panel_rise)
  );
  frtc_edge u_edge_ext (
    .clk_sys(clk_sys),
    .rst(rst),
    .level_in(external_trigger_in),
    .rise_pulse_r(ext_rise)
  );

  frtc_router u_router (
    .route_sel(route_sel_r),
    .input_mode(input_mode_r),
    .right_jack_present(right_jack_present),
    .left_audio_in(left_audio_in),
    .right_audio_in(right_audio_in),
    .delay_out_l(delay_out_l),
    .delay_out_r(delay_out_r),
    .comb_out_l(comb_out_l),
    .comb_out_r(comb_out_r),
    .delay_in_l(rt_delay_l),
    .delay_in_r(rt_delay_r),
    .comb_in_l(rt_comb_l),
    .comb_in_r(rt_comb_r),
    .out_l(rt_out_l),
    .out_r(rt_out_r)
  );

  // Simultaneous panel and external edges merge into a single event
  assign external_trigger_in_evt = panel_rise | ext_rise;
  assign frz_tgl = external_trigger_in_evt & (external_trigger_in_op_r == `FRTC_OP_FREEZE);
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes commit at the edge where the master sees ack, while it still holds the request
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  // A zero loop length would never wrap; one sample is the shortest loop
  assign fb_eff = (fb_tap_delay == `FRTC_PTR_ZERO) ? `FRTC_PTR_ONE : fb_tap_delay;
  assign rd_inc = delay_rd_ptr_r + `FRTC_PTR_ONE;

  // Three-way selections wrap in both directions
  function [1:0] step3;
    input [1:0] cur;
    input up;
    begin
      if (up)
        step3 = (cur == 2'h2) ? 2'h0 : cur + 2'h1;
      else
        step3 = (cur == 2'h0) ? 2'h2 : cur - 2'h1;
    end
  endfunction

  // Page sequence and encoder steering
  always @* begin
    page_nxt = page_r;
    route_nxt = route_sel_r;
    input_mode_nxt = input_mode_r;
    external_trigger_in_op_nxt = external_trigger_in_op_r;
    dest_nxt = random_dest_r;
    if (cfg_press) begin
      case (page_r)
        PG_IDLE: page_nxt = PG_ROUTE;
        PG_ROUTE: page_nxt = PG_INPUT;
        PG_INPUT: page_nxt = PG_EXTERNAL_TRIGGER_IN;
        PG_EXTERNAL_TRIGGER_IN: page_nxt = PG_IDLE;
        default: page_nxt = PG_IDLE;
      endcase
    end
    if (enc_up ^ enc_dn) begin
      case (page_r)
        PG_ROUTE: route_nxt = enc_up ? route_sel_r + 2'h1 : route_sel_r - 2'h1;
        PG_INPUT: input_mode_nxt = step3(input_mode_r, enc_up);
        // Only the operation moves here; freeze and reverse are view-only
        PG_EXTERNAL_TRIGGER_IN: external_trigger_in_op_nxt = step3(external_trigger_in_op_r, enc_up);
        default: route_nxt = route_sel_r;
      endcase
    end
    // Software writes take priority over a same-cycle encoder step
    if (bus_wr && wb_adr_i == `FRTC_ADR_CTRL) begin
      if (wb_sel_i[0]) begin
        route_nxt = wb_dat_i[`FRTC_CTRL_ROUTE_LSB+1:`FRTC_CTRL_ROUTE_LSB];
        if (wb_dat_i[`FRTC_CTRL_INMODE_LSB+1:`FRTC_CTRL_INMODE_LSB] != 2'h3)
          input_mode_nxt = wb_dat_i[`FRTC_CTRL_INMODE_LSB+1:`FRTC_CTRL_INMODE_LSB];
        if (wb_dat_i[`FRTC_CTRL_OP_LSB+1:`FRTC_CTRL_OP_LSB] != 2'h3)
          external_trigger_in_op_nxt = wb_dat_i[`FRTC_CTRL_OP_LSB+1:`FRTC_CTRL_OP_LSB];
      end
      if (wb_sel_i[1])
        dest_nxt = wb_dat_i[`FRTC_CTRL_DEST_LSB+`FRTC_DEST_W-1:`FRTC_CTRL_DEST_LSB];
    end
  end

  // Register read mux
  always @* begin
    rdata_nxt = 32'h00000000;
    case (wb_adr_i)
      `FRTC_ADR_CTRL: begin
        rdata_nxt[`FRTC_CTRL_ROUTE_LSB+1:`FRTC_CTRL_ROUTE_LSB] = route_sel_r;
        rdata_nxt[`FRTC_CTRL_INMODE_LSB+1:`FRTC_CTRL_INMODE_LSB] = input_mode_r;
        rdata_nxt[`FRTC_CTRL_OP_LSB+1:`FRTC_CTRL_OP_LSB] = external_trigger_in_op_r;
        rdata_nxt[`FRTC_CTRL_DEST_LSB+`FRTC_DEST_W-1:`FRTC_CTRL_DEST_LSB] = random_dest_r;
      end
      `FRTC_ADR_STATUS: begin
        rdata_nxt[7:0] = {right_adc_en_r, right_jack_present, page_r, reverse_on_r,
                          freeze_on_r};
      end
      `FRTC_ADR_RDPTR: rdata_nxt[`FRTC_PTR_W-1:0] = delay_rd_ptr_r;
      `FRTC_ADR_LOOPEND: rdata_nxt[`FRTC_PTR_W-1:0] = loop_end_r;
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Bus slave: one wait state, unmapped reads return zero and writes drop
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= rdata_nxt;
    end
  end

  // Configuration state
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      page_r <= PG_IDLE;
      route_sel_r <= `FRTC_ROUTE_RST;
      input_mode_r <= `FRTC_INMODE_RST;
      external_trigger_in_op_r <= `FRTC_OP_RST;
      random_dest_r <= `FRTC_DEST_RST;
    end else begin
      page_r <= page_nxt;
      route_sel_r <= route_nxt;
      input_mode_r <= input_mode_nxt;
      external_trigger_in_op_r <= external_trigger_in_op_nxt;
      random_dest_r <= dest_nxt;
    end
  end

  // Trigger operations
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      freeze_on_r <= 1'b0;
      reverse_on_r <= 1'b0;
      random_event_r <= 1'b0;
    end else begin
      if (frz_tgl)
        freeze_on_r <= ~freeze_on_r;
      if (external_trigger_in_evt && external_trigger_in_op_r == `FRTC_OP_REVERSE)
        reverse_on_r <= ~reverse_on_r;
      random_event_r <= external_trigger_in_evt & (external_trigger_in_op_r == `FRTC_OP_RANDOMIZE);
    end
  end

  // Delay buffer pointers; a freeze toggle owns its cycle and skips that sample's write
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= `FRTC_PTR_ZERO;
      delay_wr_ptr_r <= `FRTC_PTR_ZERO;
      delay_rd_ptr_r <= `FRTC_PTR_ZERO;
      loop_end_r <= `FRTC_PTR_ZERO;
      delay_wr_en_r <= 1'b0;
    end else begin
      delay_wr_en_r <= sample_valid & ~freeze_on_r & ~frz_tgl;
      if (frz_tgl) begin
        if (!freeze_on_r) begin
          loop_end_r <= delay_rd_ptr_r;
          delay_rd_ptr_r <= delay_rd_ptr_r - fb_eff;
        end else begin
          delay_rd_ptr_r <= delay_wr_ptr_r;
        end
      end else if (sample_valid) begin
        if (!freeze_on_r) begin
          delay_wr_ptr_r <= wr_ptr_r;
          delay_rd_ptr_r <= wr_ptr_r;
          wr_ptr_r <= wr_ptr_r + `FRTC_PTR_ONE;
        end else if (rd_inc == loop_end_r) begin
          // Loop start follows the live delay time, so the period tracks it
          delay_rd_ptr_r <= loop_end_r - fb_eff;
        end else begin
          delay_rd_ptr_r <= rd_inc;
        end
      end
    end
  end

  // Audio path registered once per sample
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      delay_in_l_r <= `FRTC_SMP_ZERO;
      delay_in_r_r <= `FRTC_SMP_ZERO;
      comb_in_l_r <= `FRTC_SMP_ZERO;
      comb_in_r_r <= `FRTC_SMP_ZERO;
      audio_out_l_r <= `FRTC_SMP_ZERO;
      audio_out_r_r <= `FRTC_SMP_ZERO;
      right_adc_en_r <= 1'b1;
    end else begin
      right_adc_en_r <= (input_mode_r != `FRTC_IN_LEFT_ONLY_MONO);
      if (sample_valid) begin
        delay_in_l_r <= rt_delay_l;
        delay_in_r_r <= rt_delay_r;
        comb_in_l_r <= rt_comb_l;
        comb_in_r_r <= rt_comb_r;
        audio_out_l_r <= rt_out_l;
        audio_out_r_r <= rt_out_r;
      end
    end
  end
endmodule // frtc_top

// File: logic/frtc_defs.vh
// Constants for the effects routing and trigger control block.
// Assumes inclusion by bare name from every design file of the block except the edge detector.
`ifndef FRTC_DEFS_VH
`define FRTC_DEFS_VH

// Datapath widths
`define FRTC_SMP_W 24
`define FRTC_PTR_W 21
`define FRTC_PTR_ONE 21'h000001
`define FRTC_PTR_ZERO 21'h000000
`define FRTC_SMP_MAX 24'h7fffff
`define FRTC_SMP_MIN 24'h800000
`define FRTC_SMP_ZERO 24'h000000

// Routing choices
`define FRTC_ROUTE_DELAY_THEN_COMB 2'h0
`define FRTC_ROUTE_COMB_THEN_DELAY 2'h1
`define FRTC_ROUTE_PARALLEL 2'h2
`define FRTC_ROUTE_SPLIT_CHANNEL 2'h3

// Input modes
`define FRTC_IN_STEREO 2'h0
`define FRTC_IN_SUMMED_MONO 2'h1
`define FRTC_IN_LEFT_ONLY_MONO 2'h2

// Trigger operations
`define FRTC_OP_FREEZE 2'h0
`define FRTC_OP_REVERSE 2'h1
`define FRTC_OP_RANDOMIZE 2'h2

// Display pages, one-hot
`define FRTC_PG_IDLE 4'h1
`define FRTC_PG_ROUTE 4'h2
`define FRTC_PG_INPUT 4'h4
`define FRTC_PG_EXTERNAL_TRIGGER_IN 4'h8

// Register byte offsets
`define FRTC_ADR_CTRL 8'h00
`define FRTC_ADR_STATUS 8'h04
`define FRTC_ADR_RDPTR 8'h08
`define FRTC_ADR_LOOPEND 8'h0c

// Control register fields
`define FRTC_CTRL_ROUTE_LSB 0
`define FRTC_CTRL_INMODE_LSB 2
`define FRTC_CTRL_OP_LSB 4
`define FRTC_CTRL_DEST_LSB 8
`define FRTC_DEST_W 4

// Reset values
`define FRTC_ROUTE_RST 2'h0
`define FRTC_INMODE_RST 2'h0
`define FRTC_OP_RST 2'h0
`define FRTC_DEST_RST 4'h0

`endif

// File: logic/frtc_edge.v
// Rising-edge detector producing one registered pulse per low-to-high step.
// Assumes the input is already synchronous to clk_sys.
`timescale 1ns/1ps
module frtc_edge (
  input wire clk_sys,
  input wire rst,
  input wire level_in,
  output reg rise_pulse_r
);
  reg prev_r;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
      rise_pulse_r <= 1'b0;
    end else begin
      prev_r <= level_in;
      // A held level gives only the first pulse
      rise_pulse_r <= level_in & ~prev_r;
    end
  end
endmodule // frtc_edge

// File: logic/frtc_router.v
// Combinational input conditioning and routing between delay and comb engines.
// Assumes the caller registers all outputs on its sample strobe.
`timescale 1ns/1ps
`include "frtc_defs.vh"
module frtc_router (
  input wire [1:0] route_sel,
  input wire [1:0] input_mode,
  input wire right_jack_present,
  input wire [`FRTC_SMP_W-1:0] left_audio_in,
  input wire [`FRTC_SMP_W-1:0] right_audio_in,
  input wire [`FRTC_SMP_W-1:0] delay_out_l,
  input wire [`FRTC_SMP_W-1:0] delay_out_r,
  input wire [`FRTC_SMP_W-1:0] comb_out_l,
  input wire [`FRTC_SMP_W-1:0] comb_out_r,
  output reg [`FRTC_SMP_W-1:0] delay_in_l,
  output reg [`FRTC_SMP_W-1:0] delay_in_r,
  output reg [`FRTC_SMP_W-1:0] comb_in_l,
  output reg [`FRTC_SMP_W-1:0] comb_in_r,
  output reg [`FRTC_SMP_W-1:0] out_l,
  output reg [`FRTC_SMP_W-1:0] out_r
);
  reg [`FRTC_SMP_W-1:0] fx_l;
  reg [`FRTC_SMP_W-1:0] fx_r;

  // Saturate rather than wrap, so a loud sum clips instead of flipping sign
  function [`FRTC_SMP_W-1:0] sat_add;
    input [`FRTC_SMP_W-1:0] a;
    input [`FRTC_SMP_W-1:0] b;
    reg [`FRTC_SMP_W:0] s;
    begin
      s = {a[`FRTC_SMP_W-1], a} + {b[`FRTC_SMP_W-1], b};
      if (s[`FRTC_SMP_W] != s[`FRTC_SMP_W-1])
        sat_add = s[`FRTC_SMP_W] ? `FRTC_SMP_MIN : `FRTC_SMP_MAX;
      else
        sat_add = s[`FRTC_SMP_W-1:0];
    end
  endfunction

  always @* begin
    fx_l = left_audio_in;
    fx_r = right_audio_in;
    case (input_mode)
      `FRTC_IN_STEREO: begin
        fx_r = right_jack_present ? right_audio_in : left_audio_in;
      end
      `FRTC_IN_SUMMED_MONO: begin
        fx_l = sat_add(left_audio_in, right_audio_in);
        fx_r = fx_l;
      end
      `FRTC_IN_LEFT_ONLY_MONO: begin
        fx_r = left_audio_in;
      end
      default: begin
        fx_r = right_audio_in;
      end
    endcase
    delay_in_l = fx_l;
    delay_in_r = fx_r;
    comb_in_l = fx_l;
    comb_in_r = fx_r;
    out_l = comb_out_l;
    out_r = comb_out_r;
    case (route_sel)
      `FRTC_ROUTE_DELAY_THEN_COMB: begin
        comb_in_l = delay_out_l;
        comb_in_r = delay_out_r;
      end
      `FRTC_ROUTE_COMB_THEN_DELAY: begin
        delay_in_l = comb_out_l;
        delay_in_r = comb_out_r;
        out_l = delay_out_l;
        out_r = delay_out_r;
      end
      `FRTC_ROUTE_PARALLEL: begin
        out_l = sat_add(delay_out_l, comb_out_l);
        out_r = sat_add(delay_out_r, comb_out_r);
      end
      `FRTC_ROUTE_SPLIT_CHANNEL: begin
        delay_in_r = `FRTC_SMP_ZERO;
        comb_in_l = `FRTC_SMP_ZERO;
        out_l = delay_out_l;
        out_r = comb_out_r;
      end
      default: begin
        out_l = comb_out_l;
      end
    endcase
  end
endmodule // frtc_router

// File: bench/frtc_top_asserts.sv
// Concurrent checks on the routing and trigger control block ports.
// Assumes engine and audio inputs are steady around each sample strobe.
`timescale 1ns/1ps
`include "frtc_defs.vh"
module frtc_top_asserts (
  input wire clk_sys,
  input wire rst,
  input wire panel_trigger_btn,
  input wire external_trigger_in,
  input wire sample_valid,
  input wire [`FRTC_SMP_W-1:0] delay_out_l,
  input wire [`FRTC_SMP_W-1:0] comb_out_l,
  input wire [`FRTC_SMP_W-1:0] comb_out_r,
  input wire [`FRTC_PTR_W-1:0] fb_tap_delay,
  input wire [`FRTC_SMP_W-1:0] delay_in_l_r,
  input wire [`FRTC_SMP_W-1:0] delay_in_r_r,
  input wire [`FRTC_SMP_W-1:0] comb_in_l_r,
  input wire [`FRTC_SMP_W-1:0] audio_out_l_r,
  input wire [`FRTC_SMP_W-1:0] audio_out_r_r,
  input wire right_adc_en_r,
  input wire delay_wr_en_r,
  input wire [`FRTC_PTR_W-1:0] delay_rd_ptr_r,
  input wire freeze_on_r,
  input wire random_event_r,
  input wire [1:0] route_sel_r,
  input wire [1:0] input_mode_r,
  input wire [1:0] external_trigger_in_op_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_ext_freeze;
    $rose(external_trigger_in) && !panel_trigger_btn && external_trigger_in_op_r == 2'h0;
  endsequence
  sequence s_toggled;
    freeze_on_r != $past(freeze_on_r);
  endsequence
  chk_route_delay_first: assert property (
    sample_valid && route_sel_r == 2'h0 |=> comb_in_l_r == $past(delay_out_l)
      && audio_out_l_r == $past(comb_out_l)) else $error("delay-first routing wrong");
  chk_route_comb_first: assert property (
    sample_valid && route_sel_r == 2'h1 |=> delay_in_l_r == $past(comb_out_l)
      && audio_out_l_r == $past(delay_out_l)) else $error("comb-first routing wrong");
  chk_split_zero_in: assert property (
    sample_valid && route_sel_r == 2'h3 |=> delay_in_r_r == `FRTC_SMP_ZERO
      && comb_in_l_r == `FRTC_SMP_ZERO) else $error("split inputs not zeroed");
  chk_split_out: assert property (
    sample_valid && route_sel_r == 2'h3 |=> audio_out_l_r == $past(delay_out_l)
      && audio_out_r_r == $past(comb_out_r)) else $error("split outputs wrong");
  chk_left_only_adc: assert property (
    input_mode_r == 2'h2 |=> !right_adc_en_r) else $error("right converter still on");
  chk_freeze_toggle: assert property (
    s_ext_freeze |-> ##[2:3] s_toggled) else $error("trigger did not toggle freeze");
  chk_freeze_jump: assert property (
    $rose(freeze_on_r) |-> delay_rd_ptr_r + $past(fb_tap_delay) == $past(delay_rd_ptr_r))
    else $error("read pointer did not step back");
  chk_frozen_hold: assert property (
    freeze_on_r && $past(freeze_on_r) && !$past(sample_valid) |-> $stable(delay_rd_ptr_r))
    else $error("frozen pointer moved without sample");
  chk_frozen_nowr: assert property (
    freeze_on_r |-> !delay_wr_en_r) else $error("buffer written while frozen");
  chk_random_pulse: assert property (
    random_event_r |-> external_trigger_in_op_r == 2'h2 ##1 !random_event_r)
    else $error("random event wrong");
endmodule // frtc_top_asserts

bind frtc_top frtc_top_asserts i_frtc_top_asserts (
  .clk_sys, .rst, .panel_trigger_btn, .external_trigger_in, .sample_valid, .delay_out_l,
  .comb_out_l, .comb_out_r, .fb_tap_delay, .delay_in_l_r, .delay_in_r_r, .comb_in_l_r,
  .audio_out_l_r, .audio_out_r_r, .right_adc_en_r, .delay_wr_en_r, .delay_rd_ptr_r,
  .freeze_on_r, .random_event_r, .route_sel_r, .input_mode_r, .external_trigger_in_op_r
);

// File: bench/frtc_engine_model.sv
// Stand-in for the delay and comb engines: fixed outputs per sample.
// Assumes the block's clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module frtc_engine_model #(
  parameter logic [23:0] DL = 24'h001000,
  parameter logic [23:0] DR = 24'h002000,
  parameter logic [23:0] CL = 24'h003000,
  parameter logic [23:0] CR = 24'h004000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sample_valid,
  output logic [23:0] delay_out_l,
  output logic [23:0] delay_out_r,
  output logic [23:0] comb_out_l,
  output logic [23:0] comb_out_r
);
  // A real engine only moves its output at a sample boundary
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {delay_out_l, delay_out_r, comb_out_l, comb_out_r} <= '0;
    end else if (sample_valid) begin
      {delay_out_l, delay_out_r, comb_out_l, comb_out_r} <= {DL, DR, CL, CR};
    end
  end
endmodule // frtc_engine_model

// File: bench/testbench.sv
// Self-checking bench for the routing and trigger control block.
// Assumes the engine model feeds the engine outputs back to the block.
`timescale 1ns/1ps
module testbench;
  localparam logic [23:0] L = 24'h000111;
  localparam logic [23:0] R = 24'h000222;
  localparam logic [23:0] DL = 24'h001000;
  localparam logic [23:0] DR = 24'h002000;
  localparam logic [23:0] CL = 24'h003000;
  localparam logic [23:0] CR = 24'h004000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_val;
  logic wb_ack_o;
  logic [4:0] btn = 5'h00;
  logic sample_valid = 1'b0;
  logic right_jack_present = 1'b1;
  logic [23:0] left_audio_in = L, right_audio_in = R;
  logic [23:0] delay_out_l, delay_out_r, comb_out_l, comb_out_r;
  logic [23:0] delay_in_l_r, delay_in_r_r, comb_in_l_r, comb_in_r_r;
  logic [23:0] audio_out_l_r, audio_out_r_r;
  logic [20:0] fb_tap_delay = 21'h000005, delay_wr_ptr_r, delay_rd_ptr_r, p;
  logic right_adc_en_r, delay_wr_en_r, freeze_on_r, reverse_on_r, random_event_r;
  logic [3:0] random_dest_r, page_r;
  logic [1:0] route_sel_r, input_mode_r, external_trigger_in_op_r;
  int num_errors = 0, checks_done = 0, rnd_cnt = 0, n;
  wire [143:0] aud = {delay_in_l_r, delay_in_r_r, comb_in_l_r, comb_in_r_r,
                      audio_out_l_r, audio_out_r_r};

  frtc_top i_frtc_top (
    .clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .config_btn(btn[0]), .enc_step_up(btn[1]),
    .enc_step_down(btn[2]), .panel_trigger_btn(btn[3]), .external_trigger_in(btn[4]),
    .sample_valid, .left_audio_in, .right_audio_in, .right_jack_present, .delay_out_l,
    .delay_out_r, .comb_out_l, .comb_out_r, .fb_tap_delay, .delay_in_l_r, .delay_in_r_r,
    .comb_in_l_r, .comb_in_r_r, .audio_out_l_r, .audio_out_r_r, .right_adc_en_r,
    .delay_wr_en_r, .delay_wr_ptr_r, .delay_rd_ptr_r, .freeze_on_r, .reverse_on_r,
    .random_event_r, .random_dest_r, .page_r, .route_sel_r, .input_mode_r, .external_trigger_in_op_r
  );
  frtc_engine_model #(.DL(DL), .DR(DR), .CL(CL), .CR(CR)) i_frtc_engine_model (
    .clk_sys, .rst, .sample_valid, .delay_out_l, .delay_out_r, .comb_out_l, .comb_out_r
  );

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (random_event_r === 1'b1) rnd_cnt <= rnd_cnt + 1;

  task automatic check(input logic [143:0] act, input logic [143:0] exp);
    checks_done++;
    if (act !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    rd_val = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic sample();
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    #1;
  endtask

  task automatic run_case(input logic [31:0] ctrl, input logic [143:0] exp);
    wb(1'b1, 8'h00, ctrl);
    sample();
    check(aud, exp);
  endtask

  // Holds the chosen buttons for hold cycles, then lets the two-edge latency land
  task automatic step(input logic [4:0] m, input int hold, input logic [3:0] pg,
                      input logic [1:0] rt, input logic [1:0] op, input logic fz, rv);
    @(posedge clk_sys);
    btn <= m;
    repeat (hold) @(posedge clk_sys);
    btn <= 5'h00;
    repeat (4) @(posedge clk_sys);
    #1;
    check({page_r, route_sel_r, external_trigger_in_op_r, freeze_on_r, reverse_on_r}, {pg, rt, op, fz, rv});
  endtask

  task automatic end_of_test();
    $display("TB: checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    check(rd_val, 32'hc4);
    wb(1'b1, 8'h04, 32'hffffffff);
    wb(1'b1, 8'h10, 32'hffffffff);
    wb(1'b1, 8'h00, 32'h0a2b);
    wb(1'b0, 8'h00, 32'h0);
    check(rd_val, 32'h0a2b);
    wb(1'b0, 8'h04, 32'h0);
    check(rd_val, 32'h44);
    wb(1'b0, 8'h10, 32'h0);
    check(rd_val, 32'h0);
    $display("TB: registers done");
    sample();
    run_case(32'h00, {L, R, DL, DR, CL, CR});
    run_case(32'h01, {CL, CR, L, R, DL, DR});
    run_case(32'h02, {L, R, L, R, DL + CL, DR + CR});
    run_case(32'h03, {L, 24'h000000, 24'h000000, R, DL, CR});
    $display("TB: routing done");
    run_case(32'h04, {L + R, L + R, DL, DR, CL, CR});
    run_case(32'h08, {L, L, DL, DR, CL, CR});
    @(posedge clk_sys);
    right_jack_present <= 1'b0;
    run_case(32'h00, {L, L, DL, DR, CL, CR});
    @(posedge clk_sys);
    right_jack_present <= 1'b1;
    wb(1'b1, 8'h00, 32'h0c);
    wb(1'b0, 8'h00, 32'h0);
    check(rd_val, 32'h0);
    $display("TB: input modes done");
    step(5'h01, 1, 4'h2, 2'h0, 2'h0, 1'h0, 1'h0);
    step(5'h02, 1, 4'h2, 2'h1, 2'h0, 1'h0, 1'h0);
    step(5'h01, 1, 4'h4, 2'h1, 2'h0, 1'h0, 1'h0);
    step(5'h01, 1, 4'h8, 2'h1, 2'h0, 1'h0, 1'h0);
    step(5'h02, 1, 4'h8, 2'h1, 2'h1, 1'h0, 1'h0);
    step(5'h04, 1, 4'h8, 2'h1, 2'h0, 1'h0, 1'h0);
    step(5'h01, 1, 4'h1, 2'h1, 2'h0, 1'h0, 1'h0);
    step(5'h02, 1, 4'h1, 2'h1, 2'h0, 1'h0, 1'h0);
    $display("TB: pages done");
    sample();
    p = delay_rd_ptr_r;
    step(5'h10, 1, 4'h1, 2'h1, 2'h0, 1'h1, 1'h0);
    check(delay_rd_ptr_r, 21'(p - 21'h000005));
    repeat (4) sample();
    check(delay_rd_ptr_r, 21'(p - 21'h000001));
    sample();
    check(delay_rd_ptr_r, 21'(p - 21'h000005));
    @(posedge clk_sys);
    fb_tap_delay <= 21'h000003;
    repeat (5) sample();
    check(delay_rd_ptr_r, 21'(p - 21'h000003));
    repeat (3) sample();
    check({delay_wr_en_r, delay_rd_ptr_r}, {1'b0, 21'(p - 21'h000003)});
    step(5'h08, 1, 4'h1, 2'h1, 2'h0, 1'h0, 1'h0);
    check(delay_rd_ptr_r, p);
    sample();
    check({delay_wr_en_r, delay_wr_ptr_r, delay_rd_ptr_r},
          {1'b1, 21'(p + 21'h000001), 21'(p + 21'h000001)});
    $display("TB: freeze done");
    wb(1'b1, 8'h00, 32'h10);
    step(5'h10, 12, 4'h1, 2'h0, 2'h1, 1'h0, 1'h1);
    step(5'h18, 1, 4'h1, 2'h0, 2'h1, 1'h0, 1'h0);
    $display("TB: reverse done");
    wb(1'b1, 8'h00, 32'h0520);
    n = rnd_cnt;
    step(5'h10, 6, 4'h1, 2'h0, 2'h2, 1'h0, 1'h0);
    check(rnd_cnt - n, 144'h1);
    check(random_dest_r, 4'h5);
    $display("TB: randomize done");
    end_of_test();
  end
endmodule // testbench
